// *** design/pin_filter.v ***
// Three-stage synchroniser with stability filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter          STABLE_CYCLES = 1,
  parameter          CW            = 22,
  parameter          INIT          = 1'b0
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        pin_raw,
  output wire        pin_clean
);
  localparam integer  LAST_I = STABLE_CYCLES - 1;
  localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

  reg          s1_ff;
  reg          s2_ff;
  reg          s3_ff;
  reg          clean_ff;
  reg [CW-1:0] cnt_ff;

  always @(posedge clk_sys) begin
    if (rst) begin
      s1_ff    <= INIT;
      s2_ff    <= INIT;
      s3_ff    <= INIT;
      clean_ff <= INIT;
      cnt_ff   <= {CW{1'b0}};
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // A new level is taken once stages two and three agree long enough
      if ((s2_ff == s3_ff) && (s3_ff != clean_ff)) begin
        if (cnt_ff >= LAST) begin
          clean_ff <= s3_ff;
          cnt_ff   <= {CW{1'b0}};
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end else begin
        cnt_ff <= {CW{1'b0}};
      end
    end
  end

  assign pin_clean = clean_ff;
endmodule // pin_filter
`default_nettype wire

// *** design/redriver_mode_control.v ***
// Mode, equalisation, link power state and serial target control
//
// Summary of operation
// - Host-port select low: DP enable from pins
// - DP data needs enable and hot-plug high
// - Each receiver lane gets own equalisation setting
// - Eq field four bits: pin1 high, pin0 low
// - Pin levels coded 00, 01, 10, 11
// - Three eq groups, sixteen settings from pin codes
// - Link state machine runs only while USB enabled
// - Disconnect until both terminations seen, then U0
// - U0 redrives; both idle moves to U1
// - U1 keeps terminations and transmit common mode
// - U2/U3 polls terminations; missing goes Disconnect
// - U2/U3 valid LFPS moves straight to U0
// - U2/U3 keeps terminations, drops common mode
// - Power good within 500 us; pins sampled then
// - Control pins debounced within 16 ms
// - Target address from two four-level pins
// - Write: address, sub-address, data, all acknowledged
// - Read starts at sub-address, last plus one, zero
// - Master ACK fetches next byte; STOP ends read
// - Sub-address alone sets next read start
// - Mode bits: off, USB, four DP, USB+two DP
// - Power-up default is USB only
`timescale 1ns/1ps
`default_nettype none
`include "redriver_mode_control_regs.vh"
module redriver_mode_control #(
  parameter          PG_CYCLES      = `PG_CYCLES,
  parameter          DB_CYCLES      = `DB_CYCLES,
  parameter          RXDET_CYCLES   = `RXDET_CYCLES,
  parameter          U1_EXIT_CYCLES = `U1_EXIT_CYCLES,
  parameter          CW             = 22
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        supply_ok,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        i2c_mode_pin,
  input  wire        dp_select_pin,
  input  wire        usb_select_pin,
  input  wire        flip_pin,
  input  wire        hot_plug_detect_in,
  input  wire [3:0]  upstream_eq_pins,
  input  wire [3:0]  downstream_eq_pins,
  input  wire [3:0]  dp_eq_pins,
  input  wire        far_term_up,
  input  wire        far_term_dn,
  input  wire        eidle_up,
  input  wire        eidle_dn,
  input  wire        lfps_valid,
  output wire        power_good,
  output wire        usb_en,
  output wire        dp_en,
  output wire        dp_four_lane,
  output wire        flip_sel,
  output wire        dp_data_en,
  output wire [3:0]  usb_link_state,
  output wire        redrive_en,
  output wire        rx_term_en,
  output wire        tx_cm_en,
  output wire        rx_detect_req,
  output wire [3:0]  upstream_rx1_eq_setting,
  output wire [3:0]  upstream_rx2_eq_setting,
  output wire [3:0]  downstream_rx_eq_setting,
  output wire [3:0]  dp_lane0_eq_setting,
  output wire [3:0]  dp_lane1_eq_setting,
  output wire [3:0]  dp_lane2_eq_setting,
  output wire [3:0]  dp_lane3_eq_setting
);
  localparam integer  PG_LAST_I = PG_CYCLES - 1;
  localparam integer  RX_LAST_I = RXDET_CYCLES - 1;
  localparam integer  U1_LAST_I = U1_EXIT_CYCLES - 1;
  // End points cut to the counter width
  localparam [CW-1:0] PG_LAST  = PG_LAST_I[CW-1:0];
  localparam [CW-1:0] RX_LAST  = RX_LAST_I[CW-1:0];
  localparam [CW-1:0] U1_LAST  = U1_LAST_I[CW-1:0];
  localparam          NPIN     = 20;
  localparam          I_SCL    = 0;
  localparam          I_SDA    = 1;
  localparam          I_HPD    = 2;
  localparam          I_USB    = 3;
  localparam          I_DP     = 4;
  localparam          I_FLIP   = 5;
  localparam          I_I2C    = 6;
  localparam          I_SUP    = 19;
  // Link power states
  localparam [3:0]    L_DISC   = 4'h1;
  localparam [3:0]    L_U0     = 4'h2;
  localparam [3:0]    L_U1     = 4'h4;
  localparam [3:0]    L_U23    = 4'h8;
  // Serial target states
  localparam [8:0]    S_IDLE   = 9'h001;
  localparam [8:0]    S_ADDR   = 9'h002;
  localparam [8:0]    S_AACK   = 9'h004;
  localparam [8:0]    S_SUB    = 9'h008;
  localparam [8:0]    S_SACK   = 9'h010;
  localparam [8:0]    S_WDAT   = 9'h020;
  localparam [8:0]    S_WACK   = 9'h040;
  localparam [8:0]    S_RDAT   = 9'h080;
  localparam [8:0]    S_RACK   = 9'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and debounce
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_db;
  assign pin_raw = {supply_ok, dp_eq_pins, downstream_eq_pins, upstream_eq_pins,
                    i2c_mode_pin, flip_pin, dp_select_pin, usb_select_pin,
                    hot_plug_detect_in, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      pin_filter #(
        .STABLE_CYCLES ((gi >= I_USB && gi <= I_FLIP) ? DB_CYCLES : 1),
        .CW            (CW),
        .INIT          ((gi <= I_SDA) ? 1'b1 : 1'b0)
      ) u_filt (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_raw   (pin_raw[gi]),
        .pin_clean (pin_db[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Internal power good and configuration sampling
  reg  [CW-1:0] pg_cnt_ff;
  reg           pg_ff;
  reg           i2c_mode_ff;
  reg  [3:0]    cfg_up_ff;
  reg  [3:0]    cfg_dn_ff;
  reg  [3:0]    cfg_dp_ff;
  wire          pg_rise;
  assign pg_rise = pin_db[I_SUP] && !pg_ff && (pg_cnt_ff == PG_LAST);

  always @(posedge clk_sys) begin
    if (rst) begin
      pg_cnt_ff   <= {CW{1'b0}};
      pg_ff       <= 1'b0;
      i2c_mode_ff <= 1'b0;
      cfg_up_ff   <= 4'h0;
      cfg_dn_ff   <= 4'h0;
      cfg_dp_ff   <= 4'h0;
    end else if (!pin_db[I_SUP]) begin
      pg_cnt_ff <= {CW{1'b0}};
      pg_ff     <= 1'b0;
    end else if (pg_rise) begin
      pg_ff       <= 1'b1;
      i2c_mode_ff <= pin_db[I_I2C];
      cfg_up_ff   <= pin_db[10:7];
      cfg_dn_ff   <= pin_db[14:11];
      cfg_dp_ff   <= pin_db[18:15];
    end else if (!pg_ff) begin
      pg_cnt_ff <= pg_cnt_ff + 1'b1;
    end
  end

  // Target address: upper bits from one pin, lower two from the other
  reg  [4:0] addr_hi;
  wire [6:0] my_addr;
  always @* begin
    case (cfg_dp_ff[1:0])
      `LVL_LOW: addr_hi = `ADDR_HI_LOW;
      `LVL_RES: addr_hi = `ADDR_HI_RES;
      `LVL_FLT: addr_hi = `ADDR_HI_FLT;
      default:  addr_hi = `ADDR_HI_HIGH;
    endcase
  end
  assign my_addr = {addr_hi, cfg_dn_ff[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Serial target port
  reg  [8:0] st_ff;
  reg  [3:0] bit_ff;
  reg  [7:0] shift_ff;
  reg  [7:0] tx_ff;
  reg  [7:0] ptr_ff;
  reg        rw_ff;
  reg        ack_ok_ff;
  reg        oe_ff;
  reg        sda_out_ff;
  reg        scl_d_ff;
  reg        sda_d_ff;
  reg  [7:0] rd_byte;
  wire       scl;
  wire       sda;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_c;
  wire       stop_c;
  wire       wr_now;
  reg  [4:0] gen_ff;
  reg  [7:0] dpa_ff;
  reg  [7:0] dpb_ff;
  reg  [7:0] usbeq_ff;
  reg  [3:0] dneq_ff;

  assign scl      = pin_db[I_SCL];
  assign sda      = pin_db[I_SDA];
  assign scl_rise = scl && !scl_d_ff;
  assign scl_fall = !scl && scl_d_ff;
  assign start_c  = scl && scl_d_ff && sda_d_ff && !sda;
  assign stop_c   = scl && scl_d_ff && !sda_d_ff && sda;
  assign wr_now   = pg_ff && !start_c && !stop_c && scl_fall && (st_ff == S_WDAT) &&
                    (bit_ff == `BYTE_BITS);

  always @* begin
    case (ptr_ff)
      `REG_GENERAL: rd_byte = {3'h0, gen_ff};
      `REG_DP_EQ_A: rd_byte = dpa_ff;
      `REG_DP_EQ_B: rd_byte = dpb_ff;
      `REG_USB_EQ:  rd_byte = usbeq_ff;
      `REG_DN_EQ:   rd_byte = {4'h0, dneq_ff};
      default:      rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      st_ff      <= S_IDLE;
      bit_ff     <= 4'h0;
      shift_ff   <= 8'h00;
      tx_ff      <= 8'h00;
      ptr_ff     <= 8'h00;
      rw_ff      <= 1'b0;
      ack_ok_ff  <= 1'b0;
      oe_ff      <= 1'b0;
      sda_out_ff <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
      if (!pg_ff || stop_c) begin
        st_ff <= S_IDLE;
        oe_ff <= 1'b0;
      end else if (start_c) begin
        st_ff  <= S_ADDR;
        bit_ff <= 4'h0;
        oe_ff  <= 1'b0;
      end else if (scl_rise) begin
        if ((st_ff == S_ADDR) || (st_ff == S_SUB) || (st_ff == S_WDAT)) begin
          shift_ff <= {shift_ff[6:0], sda};
          bit_ff   <= bit_ff + 1'b1;
        end
        if (st_ff == S_RDAT)
          bit_ff <= bit_ff + 1'b1;
        if (st_ff == S_RACK) begin
          if (sda)
            st_ff <= S_IDLE;
          else
            ack_ok_ff <= 1'b1;
        end
      end else if (scl_fall) begin
        case (st_ff)
          S_ADDR: begin
            if (bit_ff == `BYTE_BITS) begin
              bit_ff <= 4'h0;
              if (shift_ff[7:1] == my_addr) begin
                rw_ff <= shift_ff[`RW_BIT];
                oe_ff <= 1'b1;
                st_ff <= S_AACK;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            bit_ff <= 4'h0;
            if (rw_ff) begin
              tx_ff  <= rd_byte;
              oe_ff  <= ~rd_byte[7];
              ptr_ff <= ptr_ff + 1'b1;
              st_ff  <= S_RDAT;
            end else begin
              oe_ff <= 1'b0;
              st_ff <= S_SUB;
            end
          end
          S_SUB: begin
            if (bit_ff == `BYTE_BITS) begin
              ptr_ff <= shift_ff;
              bit_ff <= 4'h0;
              oe_ff  <= 1'b1;
              st_ff  <= S_SACK;
            end
          end
          S_SACK, S_WACK: begin
            oe_ff <= 1'b0;
            st_ff <= S_WDAT;
          end
          S_WDAT: begin
            if (bit_ff == `BYTE_BITS) begin
              ptr_ff <= ptr_ff + 1'b1;
              bit_ff <= 4'h0;
              oe_ff  <= 1'b1;
              st_ff  <= S_WACK;
            end
          end
          S_RDAT: begin
            if (bit_ff == `BYTE_BITS) begin
              oe_ff     <= 1'b0;
              ack_ok_ff <= 1'b0;
              st_ff     <= S_RACK;
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b0};
              oe_ff <= ~tx_ff[6];
            end
          end
          S_RACK: begin
            if (ack_ok_ff) begin
              bit_ff <= 4'h0;
              tx_ff  <= rd_byte;
              oe_ff  <= ~rd_byte[7];
              ptr_ff <= ptr_ff + 1'b1;
              st_ff  <= S_RDAT;
            end
          end
          default: st_ff <= st_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and equalisation settings
  wire eq_ovr;
  assign eq_ovr = i2c_mode_ff && gen_ff[`GEN_EQ_OVR];

  always @(posedge clk_sys) begin
    if (rst) begin
      gen_ff   <= `GEN_RESET;
      dpa_ff   <= 8'h00;
      dpb_ff   <= 8'h00;
      usbeq_ff <= 8'h00;
      dneq_ff  <= 4'h0;
    end else begin
      if (wr_now) begin
        case (ptr_ff)
          `REG_GENERAL: gen_ff   <= shift_ff[`GEN_W-1:0];
          `REG_DP_EQ_A: dpa_ff   <= shift_ff;
          `REG_DP_EQ_B: dpb_ff   <= shift_ff;
          `REG_USB_EQ:  usbeq_ff <= shift_ff;
          `REG_DN_EQ:   dneq_ff  <= shift_ff[3:0];
          default:      dneq_ff  <= dneq_ff;
        endcase
      end
      if (!eq_ovr) begin
        dpa_ff   <= {cfg_dp_ff, cfg_dp_ff};
        dpb_ff   <= {cfg_dp_ff, cfg_dp_ff};
        usbeq_ff <= {cfg_up_ff, cfg_up_ff};
        dneq_ff  <= cfg_dn_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection
  reg  [2:0] ctl_prev_ff;
  reg        pins_seen_ff;
  reg        usb_en_ff;
  reg        dp_en_ff;
  reg        four_ff;
  reg        flip_ff;
  reg        dp_data_ff;
  wire [2:0] ctl_now;
  wire       gpio;
  wire       pin_usb;
  wire       pin_dp;
  wire       nxt_usb_en;
  wire       nxt_dp_en;
  assign ctl_now    = {pin_db[I_FLIP], pin_db[I_DP], pin_db[I_USB]};
  assign gpio       = !i2c_mode_ff;
  assign pin_usb    = pins_seen_ff ? pin_db[I_USB] : 1'b1;
  assign pin_dp     = pins_seen_ff && pin_db[I_DP];
  assign nxt_usb_en = pg_ff && (gpio ? pin_usb : gen_ff[`GEN_USB]);
  assign nxt_dp_en  = pg_ff && ((gpio || gen_ff[`GEN_DP_PIN]) ? pin_dp :
                                gen_ff[`GEN_DP]);

  always @(posedge clk_sys) begin
    if (rst) begin
      ctl_prev_ff  <= 3'h0;
      pins_seen_ff <= 1'b0;
      usb_en_ff    <= 1'b0;
      dp_en_ff     <= 1'b0;
      four_ff      <= 1'b0;
      flip_ff      <= 1'b0;
      dp_data_ff   <= 1'b0;
    end else begin
      ctl_prev_ff <= ctl_now;
      if (pg_ff && (ctl_now != ctl_prev_ff))
        pins_seen_ff <= 1'b1;
      usb_en_ff  <= nxt_usb_en;
      dp_en_ff   <= nxt_dp_en;
      four_ff    <= nxt_dp_en && !nxt_usb_en;
      flip_ff    <= gpio ? pin_db[I_FLIP] : gen_ff[`GEN_FLIP];
      dp_data_ff <= nxt_dp_en && pin_db[I_HPD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link power state machine
  reg  [3:0]    lst_ff;
  reg  [3:0]    nxt_lst;
  reg  [CW-1:0] tmr_ff;
  reg           rxdet_ff;
  reg           redrive_ff;
  reg           term_ff;
  reg           cm_ff;
  wire          both_term;
  wire          both_idle;
  assign both_term = far_term_up && far_term_dn;
  assign both_idle = eidle_up && eidle_dn;

  always @* begin
    nxt_lst = lst_ff;
    case (lst_ff)
      L_DISC: if (both_term) nxt_lst = L_U0;
      L_U0:   if (both_idle) nxt_lst = L_U1;
      L_U1: begin
        if (lfps_valid || !both_idle)
          nxt_lst = L_U0;
        else if (tmr_ff == U1_LAST)
          nxt_lst = L_U23;
      end
      L_U23: begin
        if (lfps_valid)
          nxt_lst = L_U0;
        else if (rxdet_ff && !both_term)
          nxt_lst = L_DISC;
      end
      default: nxt_lst = L_DISC;
    endcase
    if (!usb_en_ff)
      nxt_lst = L_DISC;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      lst_ff     <= L_DISC;
      tmr_ff     <= {CW{1'b0}};
      rxdet_ff   <= 1'b0;
      redrive_ff <= 1'b0;
      term_ff    <= 1'b0;
      cm_ff      <= 1'b0;
    end else begin
      lst_ff <= nxt_lst;
      if (nxt_lst != lst_ff)
        tmr_ff <= {CW{1'b0}};
      else if (((lst_ff == L_U23) && (tmr_ff == RX_LAST)) ||
               ((lst_ff == L_U1) && (tmr_ff == U1_LAST)))
        tmr_ff <= {CW{1'b0}};
      else if ((lst_ff == L_U1) || (lst_ff == L_U23))
        tmr_ff <= tmr_ff + 1'b1;
      rxdet_ff   <= (lst_ff == L_U23) && (nxt_lst == L_U23) &&
                    (tmr_ff == RX_LAST);
      redrive_ff <= (nxt_lst == L_U0);
      term_ff    <= (nxt_lst != L_DISC);
      cm_ff      <= (nxt_lst == L_U0) || (nxt_lst == L_U1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sda_out                  = sda_out_ff;
  assign sda_oe                   = oe_ff;
  assign power_good               = pg_ff;
  assign usb_en                   = usb_en_ff;
  assign dp_en                    = dp_en_ff;
  assign dp_four_lane             = four_ff;
  assign flip_sel                 = flip_ff;
  assign dp_data_en               = dp_data_ff;
  assign usb_link_state           = lst_ff;
  assign redrive_en               = redrive_ff;
  assign rx_term_en               = term_ff;
  assign tx_cm_en                 = cm_ff;
  assign rx_detect_req            = rxdet_ff;
  assign upstream_rx1_eq_setting  = usbeq_ff[3:0];
  assign upstream_rx2_eq_setting  = usbeq_ff[7:4];
  assign downstream_rx_eq_setting = dneq_ff;
  assign dp_lane0_eq_setting      = dpb_ff[7:4];
  assign dp_lane1_eq_setting      = dpa_ff[7:4];
  assign dp_lane2_eq_setting      = dpb_ff[3:0];
  assign dp_lane3_eq_setting      = dpa_ff[3:0];
endmodule // redriver_mode_control
`default_nettype wire

// *** design/redriver_mode_control_regs.vh ***
// Constants for the redriver mode control block
`ifndef REDRIVER_MODE_CONTROL_REGS_VH
`define REDRIVER_MODE_CONTROL_REGS_VH

// Clock rate and timing
`define CLK_MHZ          250
`define T_PG_US          500
`define PG_CYCLES        (`T_PG_US * `CLK_MHZ)
`define T_DB_MS          16
`define DB_CYCLES        (`T_DB_MS * 1000 * `CLK_MHZ)
`define T_CFG_SU_US      50
`define T_CFG_HD_US      10
`define T_RXDET_US       100
`define RXDET_CYCLES     (`T_RXDET_US * `CLK_MHZ)
`define T_U1_EXIT_US     10
`define U1_EXIT_CYCLES   (`T_U1_EXIT_US * `CLK_MHZ)

// Register offsets
`define REG_GENERAL      8'h0a
`define REG_DP_EQ_A      8'h10
`define REG_DP_EQ_B      8'h11
`define REG_USB_EQ       8'h20
`define REG_DN_EQ        8'h21

// General register fields
`define GEN_USB          0
`define GEN_DP           1
`define GEN_FLIP         2
`define GEN_DP_PIN       3
`define GEN_EQ_OVR       4
`define GEN_W            5
`define GEN_RESET        5'h01

// Four-level pin codes
`define LVL_LOW          2'h0
`define LVL_RES          2'h1
`define LVL_FLT          2'h2
`define LVL_HIGH         2'h3

// Upper target address bits per level
`define ADDR_HI_LOW      5'h11
`define ADDR_HI_RES      5'h08
`define ADDR_HI_FLT      5'h04
`define ADDR_HI_HIGH     5'h03

// Serial byte framing
`define BYTE_BITS        4'h8
`define RW_BIT           0

`endif

// *** testbench/host_model.sv ***
// Serial bus master standing in for the port controller
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic       scl,
  output logic       sda_drv,
  input  wire logic  sda,
  output logic [7:0] rd_byte,
  output int         rd_cnt
);
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    #20 scl = 1'h1;
    #20 r = sda;
    #20 scl = 1'h0;
    #20;
  endtask
  task automatic start;
    sda_drv = 1'h0;
    #40 scl = 1'h0;
    #20;
  endtask
  task automatic stop;
    sda_drv = 1'h0;
    #20 scl = 1'h1;
    #20 sda_drv = 1'h1;
    #40;
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  task automatic rd(input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h1, r);
      rd_byte[i] = r;
    end
    bitx(nack, r);
    rd_cnt++;
  endtask
endmodule // host_model
`default_nettype wire

// *** testbench/mode_ctl_checker.sv ***
// Assertions on power-good, dp gating and link state behaviour
`timescale 1ns/1ps
`default_nettype none
module mode_ctl_checker #(
  parameter PG_CYCLES = 20
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       supply_ok,
  input wire logic       power_good,
  input wire logic       hot_plug_detect_in,
  input wire logic       dp_data_en,
  input wire logic       usb_en,
  input wire logic [3:0] usb_link_state,
  input wire logic       far_term_up,
  input wire logic       far_term_dn,
  input wire logic       eidle_up,
  input wire logic       eidle_dn,
  input wire logic       lfps_valid,
  input wire logic       rx_term_en,
  input wire logic       tx_cm_en,
  input wire logic       rx_detect_req
);
  localparam int PG_MAX = PG_CYCLES + 16;
  localparam logic [3:0] DIS = 4'h1, U0 = 4'h2, U1 = 4'h4, U23 = 4'h8;
  wire logic       terms = far_term_up && far_term_dn;
  wire logic [3:0] st    = usb_link_state;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_pg_in_time: assert property ($rose(supply_ok) |-> ##[1:PG_MAX] power_good)
    else $error("power good late");
  a_dp_needs_hpd: assert property (!hot_plug_detect_in [*6] |-> !dp_data_en)
    else $error("dp data without hot plug");
  a_usb_off_disc: assert property (!usb_en [*2] |-> st == DIS)
    else $error("link active while usb off");
  a_disc_to_u0: assert property (usb_en && st == DIS && terms |=> st == U0 || !usb_en)
    else $error("no exit from disconnect");
  a_idle_to_u1: assert property (usb_en && st == U0 && eidle_up && eidle_dn |=>
    st == U1 || !usb_en)
    else $error("no entry to U1");
  a_lfps_wake: assert property (usb_en && st == U23 && lfps_valid |=> st == U0 || !usb_en)
    else $error("no wake on lfps");
  a_u1_hold: assert property (st == U1 [*2] |-> rx_term_en && tx_cm_en)
    else $error("U1 outputs wrong");
  a_u23_hold: assert property (st == U23 [*2] |-> rx_term_en && !tx_cm_en)
    else $error("U2/U3 outputs wrong");
  a_term_lost: assert property (st == U23 && rx_detect_req && !lfps_valid && !terms |=>
    st == DIS || !usb_en)
    else $error("no disconnect on lost termination");
  c_wake: cover property (st == U23 ##1 lfps_valid);
  c_lost: cover property (rx_detect_req && !terms);
  c_dp_data: cover property (dp_data_en);
endmodule // mode_ctl_checker
bind redriver_mode_control mode_ctl_checker #(.PG_CYCLES(PG_CYCLES))
  mode_ctl_checker_inst (.*);
`default_nettype wire

// *** testbench/redriver_mode_control_bench.sv ***
// Self-checking bench for the redriver mode control block
`timescale 1ns/1ps
`default_nettype none
module redriver_mode_control_bench;
  localparam logic [7:0] ADR = {5'h04, 2'h1, 1'h0};
  logic clk_sys = 1'h0, rst = 1'h1, supply_ok = 1'h0, i2c_mode_pin = 1'h1, scl_in, mst_sda;
  logic dp_select_pin = 1'h0, usb_select_pin = 1'h0, flip_pin = 1'h0, hot_plug_detect_in = 1'h0;
  logic far_term_up = 1'h0, far_term_dn = 1'h0, eidle_up = 1'h0, eidle_dn = 1'h0;
  logic lfps_valid = 1'h0;
  logic [3:0] upstream_eq_pins, downstream_eq_pins, dp_eq_pins;
  logic [7:0] a, b, rd_byte, q[$];
  int errors = 0, samples_checked = 0, cyc = 0, seed = 71824, rd_cnt;
  wire logic sda_out, sda_oe, power_good, usb_en, dp_en, dp_four_lane, flip_sel, dp_data_en;
  wire logic redrive_en, rx_term_en, tx_cm_en, rx_detect_req;
  wire logic [3:0] usb_link_state, upstream_rx1_eq_setting, upstream_rx2_eq_setting;
  wire logic [3:0] downstream_rx_eq_setting, dp_lane0_eq_setting, dp_lane1_eq_setting;
  wire logic [3:0] dp_lane2_eq_setting, dp_lane3_eq_setting;
  // Data line has a pull-up: high unless someone pulls it low
  wire logic sda_in = mst_sda & ((sda_oe !== 1'h1) | (sda_out === 1'h1));
  redriver_mode_control #(.PG_CYCLES(20), .DB_CYCLES(8), .RXDET_CYCLES(16),
    .U1_EXIT_CYCLES(8)) redriver_mode_control_inst (.*);
  host_model host_model_inst (.scl(scl_in), .sda_drv(mst_sda), .sda(sda_in),
    .rd_byte(rd_byte), .rd_cnt(rd_cnt));
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wb(input logic [7:0] d, input logic exp_ack);
    logic k;
    host_model_inst.wr(d, k);
    chk(8'(k), 8'(exp_ack));
  endtask
  task automatic wreg(input logic [7:0] sub, d0, d1, input int n);
    host_model_inst.start;
    wb(ADR, 1'h1);
    wb(sub, 1'h1);
    if (n > 0) wb(d0, 1'h1);
    if (n > 1) wb(d1, 1'h1);
    host_model_inst.stop;
    tick(8);
  endtask
  task automatic rd(input int n);
    host_model_inst.start;
    wb(ADR | 8'h01, 1'h1);
    for (int i = 1; i <= n; i++) host_model_inst.rd(i == n);
    #20;
    chk(8'(sda_oe), 8'h00);
    host_model_inst.stop;
  endtask
  always @(rd_cnt) chk(rd_byte, q.pop_front());
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results;
    end
  end
  initial begin
    upstream_eq_pins = 4'($random(seed));
    downstream_eq_pins = {2'($random(seed)), 2'h1};
    dp_eq_pins = {2'($random(seed)), 2'h2};
    tick(16);
    rst = 1'h0;
    tick(1);
    supply_ok = 1'h1;
    for (int i = 0; i < 60 && power_good !== 1'h1; i++) tick(1);
    tick(2);
    chk(8'({power_good, usb_en, dp_en}), 8'h06);
    chk({upstream_rx2_eq_setting, upstream_rx1_eq_setting}, {2{upstream_eq_pins}});
    chk({downstream_rx_eq_setting, dp_lane0_eq_setting}, {downstream_eq_pins, dp_eq_pins});
    chk({dp_lane1_eq_setting, dp_lane2_eq_setting}, {2{dp_eq_pins}});
    chk({dp_lane3_eq_setting, 4'h0}, {dp_eq_pins, 4'h0});
    host_model_inst.start;
    wb(ADR ^ 8'h80, 1'h0);
    host_model_inst.stop;
    $display("power-up done");
    hot_plug_detect_in = 1'h1;
    for (int m = 0; m < 8; m++) begin
      wreg(8'h0a, 8'(m), 8'h00, 1);
      chk(8'({usb_en, dp_en, dp_four_lane, flip_sel, dp_data_en}),
          8'({m[0], m[1], m[1:0] == 2'h2, m[2], m[1]}));
    end
    wreg(8'h0a, 8'h08, 8'h00, 1);
    dp_select_pin = 1'h1;
    tick(24);
    chk(8'({usb_en, dp_en}), 8'h01);
    $display("modes done");
    a = 8'($random(seed));
    b = 8'($random(seed));
    wreg(8'h0a, 8'h11, 8'h00, 1);
    wreg(8'h20, a, b, 2);
    chk({upstream_rx2_eq_setting, upstream_rx1_eq_setting}, a);
    chk(8'(downstream_rx_eq_setting), 8'(b[3:0]));
    wreg(8'h1f, 8'h00, 8'h00, 0);
    q.push_back(8'h00);
    q.push_back(a);
    rd(2);
    q.push_back(8'(b[3:0]));
    rd(1);
    $display("registers done");
    wreg(8'h0a, 8'h01, 8'h00, 1);
    far_term_up = 1'h1;
    far_term_dn = 1'h1;
    tick(2);
    chk(8'({usb_link_state, redrive_en}), 8'h05);
    eidle_up = 1'h1;
    eidle_dn = 1'h1;
    tick(2);
    chk(8'({usb_link_state, rx_term_en, tx_cm_en}), 8'h13);
    tick(12);
    chk(8'({usb_link_state, rx_term_en, tx_cm_en}), 8'h22);
    lfps_valid = 1'h1;
    tick(1);
    chk(8'(usb_link_state), 8'h02);
    lfps_valid = 1'h0;
    tick(16);
    far_term_dn = 1'h0;
    tick(24);
    chk(8'(usb_link_state), 8'h01);
    far_term_dn = 1'h1;
    wreg(8'h0a, 8'h00, 8'h00, 1);
    chk(8'({usb_en, usb_link_state}), 8'h01);
    $display("link done");
    rst = 1'h1;
    supply_ok = 1'h0;
    i2c_mode_pin = 1'h0;
    tick(16);
    rst = 1'h0;
    supply_ok = 1'h1;
    tick(40);
    chk(8'({power_good, usb_en, dp_en}), 8'h06);
    usb_select_pin = 1'h1;
    tick(24);
    chk(8'({usb_en, dp_en, dp_four_lane, dp_data_en}), 8'h0d);
    hot_plug_detect_in = 1'h0;
    tick(8);
    chk(8'(dp_data_en), 8'h00);
    $display("pin control done");
    results;
  end
endmodule // redriver_mode_control_bench
`default_nettype wire
